// >>> hw/mms_sequencer.sv
// Monitor output mux sequencer with its register port
`timescale 1ns/100ps
module mms_sequencer #(
  parameter int TIMEOUT = mms_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  // Pins
  input  wire logic        slotAdvancePin,
  input  wire logic        enableN,
  input  wire logic        enableFloat,
  // Differential output control
  output logic             diffOutEn,
  output logic      [3:0]  slotIndex,
  output logic             slotReversed
);
  import mms_pkg::*;

  // =============================================
  // Registers
  logic [7:0] chanEn;
  logic [7:0] skipReg;
  logic [7:0] altReg;
  logic [7:0] timeoutReg;
  logic [7:0] sChanEn;
  logic [7:0] sSkip;
  logic       sAlt;

  mms_phase_type phase;
  logic [3:0]    cnt;
  mms_pos_type   next_pos;
  mms_pos_type   walkLive;
  mms_pos_type   walkShadow;
  logic          advance;
  logic          restart;
  logic          functional;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chanEn     <= CHAN_EN_RESET;
      skipReg    <= SKIP_RESET;
      altReg     <= ALT_RESET;
      timeoutReg <= TIMEOUT_RESET;
    end else if (regWrite) begin
      unique case (regAddr)
        REG_CHAN_EN: chanEn     <= regWdata;
        REG_SKIP:    skipReg    <= regWdata;
        REG_ALT:     altReg     <= regWdata;
        REG_TIMEOUT: timeoutReg <= regWdata;
        default: ;
      endcase
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        REG_CHAN_EN: regRdata <= chanEn;
        REG_SKIP:    regRdata <= skipReg;
        REG_ALT:     regRdata <= altReg;
        REG_TIMEOUT: regRdata <= timeoutReg;
        REG_STATUS:  regRdata <= {slotReversed, phase, diffOutEn, slotIndex};
        default:     regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // =============================================
  // Slot selection
  function automatic logic [SLOT_COUNT-1:0] slotMask(input logic [7:0] en);
    logic [SLOT_COUNT-1:0] m;
    m = '0;
    for (int i = 0; i < CHAN_COUNT; i++) begin
      m[2*i]   = en[i];
      m[2*i+1] = en[i];
    end
    m[SLOT_CURRENT_MONITOR_INPUT_ONE] = en[AUX_CURRENT_MONITOR_INPUT_ONE_BIT];
    m[SLOT_CURRENT_MONITOR_INPUT_TWO] = en[AUX_CURRENT_MONITOR_INPUT_TWO_BIT];
    m[SLOT_GND]   = en[AUX_GND_BIT];
    return m;
  endfunction

  // Lowest enabled slot at or above the start index
  function automatic logic [4:0] firstFrom(input logic [SLOT_COUNT-1:0] m, input logic [4:0] from);
    logic [4:0] r;
    r = 5'h00;
    for (int i = SLOT_COUNT - 1; i >= 0; i--) begin
      if (m[i] && 5'(i) >= from) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // Walks from an entry point to the next position that consumes a pulse
  function automatic mms_pos_type walk(input mms_entry_type entry, input logic [7:0] en,
                                       input logic [7:0] skip, input logic alt,
                                       input logic rev, input logic [4:0] from);
    mms_pos_type   p;
    mms_entry_type e;
    logic          busy;
    logic [4:0]    pick;
    p    = '{fin: 1'b0, ph: MMS_START, cnt: 4'h0, slot: 4'h0, rev: rev};
    e    = entry;
    busy = 1'b1;
    pick = 5'h00;
    for (int k = 0; k < 8; k++) begin
      if (busy) begin
        unique case (e)
          MMS_E_PASS: begin
            if (skip[7:SKIP_LSB] != 4'h0) begin
              p.ph  = MMS_SKIP;
              p.cnt = 4'h1;
              busy  = 1'b0;
            end else begin
              e = MMS_E_OWN;
            end
          end
          MMS_E_OWN: begin
            // The reversed pass starts again at the lowest slot
            pick = firstFrom(slotMask(en), (e == entry && p.rev == rev) ? from : 5'h00);
            if (pick[4]) begin
              p.ph   = MMS_OWN;
              p.slot = pick[3:0];
              busy   = 1'b0;
            end else begin
              e = MMS_E_TRAIL;
            end
          end
          MMS_E_TRAIL: begin
            if (skip[TRAIL_LSB+3:TRAIL_LSB] != 4'h0) begin
              p.ph  = MMS_TRAIL;
              p.cnt = 4'h1;
              busy  = 1'b0;
            end else begin
              e = MMS_E_END;
            end
          end
          MMS_E_END: begin
            if (alt && !p.rev) begin
              p.rev = 1'b1;
              e     = MMS_E_PASS;
            end else begin
              p.fin = 1'b1;
              busy  = 1'b0;
            end
          end
        endcase
      end
    end
    return p;
  endfunction

  // =============================================
  // Sequencer
  assign functional = !enableN && !enableFloat;

  always_comb begin
    walkLive   = walk(MMS_E_PASS, chanEn, skipReg, altReg[ALT_BIT], 1'b0, 5'h00);
    walkShadow = '{fin: 1'b1, ph: MMS_START, cnt: 4'h0, slot: 4'h0, rev: 1'b0};
    unique case (phase)
      MMS_START: walkShadow.fin = 1'b1;
      MMS_SKIP: begin
        if (cnt < sSkip[7:SKIP_LSB]) begin
          walkShadow = '{fin: 1'b0, ph: MMS_SKIP, cnt: cnt + 4'h1, slot: slotIndex, rev: slotReversed};
        end else begin
          walkShadow = walk(MMS_E_OWN, sChanEn, sSkip, sAlt, slotReversed, 5'h00);
        end
      end
      MMS_OWN: begin
        walkShadow = walk(MMS_E_OWN, sChanEn, sSkip, sAlt, slotReversed, {1'b0, slotIndex} + 5'h01);
      end
      MMS_TRAIL: begin
        if (cnt < sSkip[TRAIL_LSB+3:TRAIL_LSB]) begin
          walkShadow = '{fin: 1'b0, ph: MMS_TRAIL, cnt: cnt + 4'h1, slot: slotIndex, rev: slotReversed};
        end else begin
          walkShadow = walk(MMS_E_END, sChanEn, sSkip, sAlt, slotReversed, 5'h00);
        end
      end
    endcase
    next_pos = walkShadow.fin ? walkLive : walkShadow;
  end

  mms_select_watch #(
    .TIMEOUT (TIMEOUT)
  ) u_watch (
    .clk            (clk),
    .arst_n         (arst_n),
    .slotAdvancePin (slotAdvancePin),
    .enableN        (enableN),
    .timeoutOn      (!timeoutReg[TIMEOUT_OFF_BIT]),
    .advance        (advance),
    .restart        (restart)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase        <= MMS_START;
      cnt          <= 4'h0;
      slotIndex    <= 4'h0;
      slotReversed <= 1'b0;
    end else if (!functional || restart) begin
      phase        <= MMS_START;
      cnt          <= 4'h0;
      slotIndex    <= 4'h0;
      slotReversed <= 1'b0;
    end else if (advance) begin
      phase        <= next_pos.fin ? MMS_START : next_pos.ph;
      cnt          <= next_pos.cnt;
      slotIndex    <= next_pos.slot;
      slotReversed <= next_pos.rev;
    end
  end

  // Configuration is latched only when a new select cycle begins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sChanEn <= CHAN_EN_RESET;
      sSkip   <= SKIP_RESET;
      sAlt    <= 1'b0;
    end else if (functional && !restart && advance && walkShadow.fin) begin
      sChanEn <= chanEn;
      sSkip   <= skipReg;
      sAlt    <= altReg[ALT_BIT];
    end
  end

  assign diffOutEn = functional && (phase == MMS_OWN);

endmodule // mms_sequencer

// >>> hw/mms_pkg.sv
// Package with constants and types for the monitor output mux sequencer
// =============================================
package mms_pkg;

  // =============================================
  // Register map
  localparam logic [7:0] REG_CHAN_EN    = 8'h04;
  localparam logic [7:0] REG_SKIP       = 8'h05;
  localparam logic [7:0] REG_ALT        = 8'h06;
  localparam logic [7:0] REG_TIMEOUT    = 8'h0F;
  localparam logic [7:0] REG_STATUS     = 8'h30;
  localparam logic [7:0] CHAN_EN_RESET  = 8'h0F;
  localparam logic [7:0] SKIP_RESET     = 8'h00;
  localparam logic [7:0] ALT_RESET      = 8'h00;
  localparam logic [7:0] TIMEOUT_RESET  = 8'h00;

  // =============================================
  // Field positions
  localparam int CHAN_COUNT     = 4;
  localparam int AUX_CURRENT_MONITOR_INPUT_ONE_BIT  = 4;
  localparam int AUX_CURRENT_MONITOR_INPUT_TWO_BIT  = 5;
  localparam int AUX_GND_BIT    = 6;
  localparam int ALT_BIT        = 7;
  localparam int TIMEOUT_OFF_BIT = 7;
  localparam int SKIP_LSB       = 4;
  localparam int TRAIL_LSB      = 0;

  // =============================================
  // Slot codes
  localparam int SLOT_COUNT     = 11;
  localparam logic [3:0] SLOT_CURRENT_MONITOR_INPUT_ONE = 4'h8;
  localparam logic [3:0] SLOT_CURRENT_MONITOR_INPUT_TWO = 4'h9;
  localparam logic [3:0] SLOT_GND   = 4'hA;

  // =============================================
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TIMEOUT_US     = 45;
  localparam int TIMEOUT_CYCLES = (TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // =============================================
  // Types
  typedef enum logic [1:0] {
    MMS_START,
    MMS_SKIP,
    MMS_OWN,
    MMS_TRAIL
  } mms_phase_type;

  typedef enum logic [1:0] {
    MMS_E_PASS,
    MMS_E_OWN,
    MMS_E_TRAIL,
    MMS_E_END
  } mms_entry_type;

  typedef struct packed {
    logic          fin;
    mms_phase_type ph;
    logic [3:0]    cnt;
    logic [3:0]    slot;
    logic          rev;
  } mms_pos_type;

endpackage

// >>> hw/mms_select_watch.sv
// Select line edge detector, restart timeout and enable toggle detector
`timescale 1ns/100ps
module mms_select_watch #(
  parameter int TIMEOUT = mms_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Pins
  input  wire logic slotAdvancePin,
  input  wire logic enableN,
  // Control
  input  wire logic timeoutOn,
  // Events
  output logic      advance,
  output logic      restart
);
  import mms_pkg::*;

  localparam int CW = $clog2(TIMEOUT + 1);

  logic          selPrev;
  logic          enPrev;
  logic [CW-1:0] stableCnt;
  logic          selChange;

  assign selChange = slotAdvancePin != selPrev;
  assign advance   = slotAdvancePin & ~selPrev;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      selPrev <= 1'b0;
      // Idle level of the enable is low, so no false restart follows reset
      enPrev  <= 1'b0;
    end else begin
      selPrev <= slotAdvancePin;
      enPrev  <= enableN;
    end
  end

  // Counts cycles at a steady select level, saturating once fired
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stableCnt <= '0;
    end else if (selChange) begin
      stableCnt <= '0;
    end else if (stableCnt != CW'(TIMEOUT)) begin
      stableCnt <= stableCnt + CW'(1);
    end
  end

  assign restart = (timeoutOn && !selChange && stableCnt >= CW'(TIMEOUT - 1))
                   || (enableN != enPrev);

endmodule // mms_select_watch

// >>> verif/mms_sequencer_checker.sv
// Checker for the monitor output mux sequencer
`timescale 1ns/100ps
module mms_sequencer_checker
  import mms_pkg::*;
#(
  parameter int TIMEOUT = TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  // Pins
  input wire logic       slotAdvancePin,
  input wire logic       enableN,
  input wire logic       enableFloat,
  input wire logic       diffOutEn,
  input wire logic [3:0] slotIndex,
  input wire logic       slotReversed
);
  logic       pinQ, pulseQ, togQ, enQ, toOff, altEver;
  logic [7:0] skipQ;
  int         cnt;
  // ====
  // Shadow of pin history and register writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {pinQ, pulseQ, togQ, enQ, toOff, altEver} <= 6'h00;
      skipQ <= 8'h00;
      cnt   <= 0;
    end else begin
      pinQ   <= slotAdvancePin;
      pulseQ <= slotAdvancePin && !pinQ;
      togQ   <= enableN != enQ;
      enQ    <= enableN;
      cnt    <= (slotAdvancePin != pinQ) ? 0 : ((cnt < TIMEOUT + 4) ? cnt + 1 : cnt);
      if (regWrite && regAddr == REG_TIMEOUT) toOff <= regWdata[TIMEOUT_OFF_BIT];
      if (regWrite && regAddr == REG_SKIP) skipQ <= regWdata;
      if (regWrite && regAddr == REG_ALT && regWdata[ALT_BIT]) altEver <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence en_toggle_seq;
    $changed(enableN) && !enableFloat;
  endsequence
  // ====
  // Assertions
  chk_float_when_held: assert property ((enableFloat || enableN) |-> !diffOutEn)
    else $error("output driven while disabled");
  chk_restart_floats: assert property (en_toggle_seq |=> !diffOutEn)
    else $error("no float after enable toggle");
  chk_slot_after_edge: assert property ($changed(slotIndex) && diffOutEn && !togQ |-> pulseQ)
    else $error("slot moved without pulse");
  chk_timeout_restart: assert property (!toOff && $past(!toOff) && cnt >= TIMEOUT + 1 |-> !diffOutEn)
    else $error("no restart after timeout");
  chk_hold_still: assert property (!pulseQ && !togQ && $stable(enableN) && $stable(enableFloat)
    && $past(enableFloat, 2) == enableFloat && !(!toOff && cnt >= TIMEOUT - 1)
    |-> $stable(slotIndex) && $stable(diffOutEn))
    else $error("output moved between pulses");
  chk_rev_needs_alt: assert property ($rose(slotReversed) |-> altEver)
    else $error("reversed pass without alternating");
  chk_index_range: assert property (diffOutEn |-> slotIndex <= SLOT_GND)
    else $error("slot code out of range");
  chk_skip_readback: assert property (regRead && regAddr == REG_SKIP |=> regRdata == skipQ)
    else $error("skip count readback wrong");
endmodule // mms_sequencer_checker

bind mms_sequencer mms_sequencer_checker #(.TIMEOUT(TIMEOUT)) u_checker (.clk(clk), .arst_n(arst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .slotAdvancePin(slotAdvancePin), .enableN(enableN), .enableFloat(enableFloat), .diffOutEn(diffOutEn),
  .slotIndex(slotIndex), .slotReversed(slotReversed));

// >>> verif/mms_ctrl_model.sv
// Controller model that paces select pulses and samples the output
`timescale 1ns/100ps
module mms_ctrl_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Bench request
  input  wire logic       req,
  input  wire logic [3:0] gap,
  output logic            busy,
  // Device side
  output logic            slotAdvancePin,
  input  wire logic       diffOutEn,
  input  wire logic [3:0] slotIndex,
  input  wire logic       slotReversed,
  // Sample
  output logic            smpEn,
  output logic      [3:0] smpIdx,
  output logic            smpRev
);
  logic [4:0] step;
  assign busy = step != 5'h00;
  // ====
  // One-cycle pulse, then low for at least one sample plus the gap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      step           <= 5'h00;
      slotAdvancePin <= 1'b0;
    end else if (!busy) begin
      step           <= {4'h0, req};
      slotAdvancePin <= req;
    end else begin
      slotAdvancePin <= 1'b0;
      step           <= (step >= 5'h02 + {1'b0, gap}) ? 5'h00 : step + 5'h01;
    end
  end
  // Sample once per pulse after settling
  always_ff @(posedge clk) begin
    if (step == 5'h02) begin
      {smpRev, smpEn, smpIdx} <= {slotReversed, diffOutEn, slotIndex};
    end
  end
endmodule // mms_ctrl_model

// >>> verif/test_monitor_output_mux_sequencer.sv
// Self-checking bench for the monitor output mux sequencer
`timescale 1ns/100ps
module test_monitor_output_mux_sequencer;
  import mms_pkg::*;
  localparam int TO = 20;
  logic       clk, arst_n, regWrite, regRead, enableN, enableFloat, req, busy;
  logic       slotAdvancePin, diffOutEn, slotReversed, smpEn, smpRev;
  logic [7:0] regAddr, regWdata, regRdata;
  logic [3:0] gap, slotIndex, smpIdx;
  logic [7:0] q[$];
  int         num_errors, checks;
  always #5 clk = ~clk;
  mms_sequencer #(.TIMEOUT(TO)) DUT (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .slotAdvancePin(slotAdvancePin),
    .enableN(enableN), .enableFloat(enableFloat), .diffOutEn(diffOutEn), .slotIndex(slotIndex),
    .slotReversed(slotReversed));
  mms_ctrl_model ctrl (.clk(clk), .arst_n(arst_n), .req(req), .gap(gap), .busy(busy),
    .slotAdvancePin(slotAdvancePin), .diffOutEn(diffOutEn), .slotIndex(slotIndex),
    .slotReversed(slotReversed), .smpEn(smpEn), .smpIdx(smpIdx), .smpRev(smpRev));
  // ====
  // Tasks
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    cmp(regRdata, exp);
  endtask
  // Float code 8'h80, else {rev, index}
  task automatic pulse(input logic [7:0] exp);
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    #1;
    while (busy) begin
      @(posedge clk);
      #1;
    end
    if (exp[7]) cmp({7'h00, smpEn}, 8'h00);
    else cmp({smpRev, 2'b00, smpEn, smpIdx}, {exp[4], 3'b001, exp[3:0]});
  endtask
  task automatic run_q();
    foreach (q[i]) pulse(q[i]);
  endtask
  task automatic floats(input int n);
    repeat (n) @(posedge clk);
    #1;
    cmp({7'h00, diffOutEn}, 8'h00);
  endtask
  task automatic final_report();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
  // ====
  // Tests
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {regAddr, regWdata, regWrite, regRead} = 18'h00000;
    {enableN, enableFloat, req, gap} = 7'h00;
    num_errors = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rd(REG_CHAN_EN, CHAN_EN_RESET);
    rd(REG_SKIP, SKIP_RESET);
    rd(REG_ALT, ALT_RESET);
    rd(REG_TIMEOUT, TIMEOUT_RESET);
    rd(8'h01, 8'h00);
    floats(0);
    for (int i = 0; i < 9; i++) pulse(8'(i % 8));
    floats(TO + 4);
    wr(REG_TIMEOUT, 8'h80);
    pulse(8'h00);
    pulse(8'h01);
    repeat (3 * TO) @(posedge clk);
    pulse(8'h02);
    rd(REG_STATUS, 8'h52);
    wr(REG_TIMEOUT, 8'h00);
    floats(TO);
    wr(REG_CHAN_EN, 8'h75);
    wr(REG_ALT, 8'h80);
    gap <= 4'h3;
    floats(TO + 4);
    pulse(8'h00);
    wr(REG_CHAN_EN, 8'h0F);
    q = '{8'h01, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0A, 8'h10, 8'h11, 8'h14, 8'h15, 8'h18, 8'h19, 8'h1A, 8'h00,
          8'h01, 8'h02};
    run_q();
    wr(REG_CHAN_EN, 8'h01);
    wr(REG_SKIP, 8'h20);
    rd(REG_SKIP, 8'h20);
    floats(TO + 4);
    q = '{8'h80, 8'h80, 8'h00, 8'h01, 8'h80, 8'h80, 8'h10, 8'h11, 8'h80, 8'h80, 8'h00};
    run_q();
    wr(REG_ALT, 8'h00);
    wr(REG_SKIP, 8'h02);
    floats(TO + 4);
    q = '{8'h00, 8'h01, 8'h80, 8'h80, 8'h00};
    run_q();
    wr(REG_SKIP, 8'h00);
    wr(REG_CHAN_EN, 8'h0F);
    floats(TO + 4);
    pulse(8'h00);
    pulse(8'h01);
    @(posedge clk) enableN <= 1'b1;
    floats(1);
    @(posedge clk) enableN <= 1'b0;
    floats(1);
    pulse(8'h00);
    @(posedge clk) enableFloat <= 1'b1;
    pulse(8'h80);
    @(posedge clk) enableFloat <= 1'b0;
    pulse(8'h00);
    final_report();
  end
endmodule // test_monitor_output_mux_sequencer
